// ---- core/ctu_pkg.sv ----
// Shared constants, register map and types of the charge time unit.
package ctu_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFF_MAIN = 8'h00;
  localparam logic [7:0] OFF_EDGE = 8'h04;
  localparam logic [7:0] OFF_CURR = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0c;
  localparam logic [7:0] OFF_MASK = 8'h10;

  // Main control register fields.
  localparam int MAIN_EN        = 7;
  localparam int MAIN_IDLE_STOP = 5;
  localparam int MAIN_DELAY     = 4;
  localparam int MAIN_GATE      = 3;
  localparam int MAIN_ORDER     = 2;
  localparam int MAIN_DISCH     = 1;
  localparam int MAIN_TRIG      = 0;
  localparam logic [7:0] MAIN_MASK = 8'hbf;

  // Edge control register fields.
  localparam int EDGE_TWO_POL = 7;
  localparam int EDGE_TWO_SRC = 5;
  localparam int EDGE_ONE_POL = 4;
  localparam int EDGE_ONE_SRC = 2;
  localparam int EDGE_TWO_FLG = 1;
  localparam int EDGE_ONE_FLG = 0;

  // Current control register fields.
  localparam int CURR_TRIM  = 2;
  localparam int CURR_RANGE = 0;
  localparam logic [1:0] RANGE_OFF = 2'h0;

  // Edge source codes; the code is also the bit index in the source vector.
  localparam logic [1:0] SRC_PIN_FIRST  = 2'h3;
  localparam logic [1:0] SRC_PIN_SECOND = 2'h2;
  localparam logic [1:0] SRC_PWM_FIRST  = 2'h1;
  localparam logic [1:0] SRC_PWM_SECOND = 2'h0;

  // Interrupt status and mask fields.
  localparam int IRQ_EDGE_ONE = 0;
  localparam int IRQ_EDGE_TWO = 1;
  localparam int IRQ_TRIP     = 2;
  localparam int IRQ_W        = 3;

  // Reset values.
  localparam logic [7:0]       RST_REG = 8'h00;
  localparam logic [IRQ_W-1:0] RST_IRQ = 3'h0;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0]
  {
    ST_IDLE   = 3'b001,
    ST_CHARGE = 3'b010,
    ST_DONE   = 3'b100
  } ctu_state_type;

  function automatic logic ctu_reg_hit(input logic [7:0] addr);
    return (addr == OFF_MAIN) || (addr == OFF_EDGE) || (addr == OFF_CURR) ||
           (addr == OFF_STAT) || (addr == OFF_MASK);
  endfunction

endpackage

// ---- core/ctu_bus_if.sv ----
// Register access carrier between the bus slave and the register file.
`timescale 1ns/100ps
interface ctu_bus_if;
  logic       wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic       wr_strb;
  logic       wr_err;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic       rd_err;

  modport slave (output wr_en, wr_addr, wr_data, wr_strb, rd_addr, input wr_err, rd_data, rd_err);
  modport regs  (input wr_en, wr_addr, wr_data, wr_strb, rd_addr, output wr_err, rd_data, rd_err);
endinterface

// ---- core/ctu_edge.sv ----
// Edge source selection and polarity detection for both edge channels.
`timescale 1ns/100ps
module ctu_edge
  import ctu_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst,
  // Source levels, indexed by source code.
  input  wire logic [3:0] sources,
  // Configuration.
  input  wire logic [1:0] src_one,
  input  wire logic [1:0] src_two,
  input  wire logic       pol_one,
  input  wire logic       pol_two,
  // Detected edges.
  output logic            hit_one,
  output logic            hit_two
);

  logic [3:0] prev;

  function automatic logic edge_hit(input logic [3:0] old_v, input logic [3:0] new_v,
                                    input logic [1:0] sel, input logic pol);
    return pol ? (!old_v[sel] && new_v[sel]) : (old_v[sel] && !new_v[sel]);
  endfunction

  always_ff @(posedge clk)
  begin
    // Tracking the sources through reset keeps a source that idles high from looking like an edge on release.
    if (rst)
      prev <= sources;
    else
      prev <= sources;
  end

  assign hit_one = edge_hit(prev, sources, src_one, pol_one);
  assign hit_two = edge_hit(prev, sources, src_two, pol_two);

endmodule

// ---- core/ctu_axil.sv ----
// AXI4-Lite slave that turns bus transfers into register strobes.
`timescale 1ns/100ps
module ctu_axil
  import ctu_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // Write address and data.
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // Write response.
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // Read.
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Register side.
  ctu_bus_if.slave         bus
);

  logic [7:0] aw_addr;
  logic [7:0] w_data;
  logic       w_strb;
  logic       do_write;

  // A write fires once both halves are held and no response is pending.
  assign do_write    = !awready && !wready && !bvalid;
  assign bus.wr_en   = do_write;
  assign bus.wr_addr = aw_addr;
  assign bus.wr_data = w_data;
  assign bus.wr_strb = w_strb;
  assign bus.rd_addr = araddr;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      aw_addr <= 8'h00;
      w_data  <= 8'h00;
      w_strb  <= 1'b0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awready <= 1'b0;
        aw_addr <= awaddr;
      end
      if (wvalid && wready)
      begin
        wready <= 1'b0;
        w_data <= wdata[7:0];
        w_strb <= wstrb[0];
      end
      if (do_write)
      begin
        bvalid  <= 1'b1;
        bresp   <= bus.wr_err ? RESP_SLVERR : RESP_OKAY;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= {24'h00_0000, bus.rd_data};
      rresp   <= bus.rd_err ? RESP_SLVERR : RESP_OKAY;
    end
    else if (rvalid && rready)
    begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

endmodule

// ---- core/ctu_top.sv ----
// Charge time unit: registers, edge control, current source and delay pulse.
//
// Notes on behaviour
// - Delay mode bit drives pulse on pulse pin.
// - Delay mode: edge one charges, trip ends pulse.
// - Sleep always switches the current source off.
// - Idle stop bit switches source off in Idle.
// - Power disable freezes unit, outputs off; DISCHARGE, CURRENT_RANGE and CURRENT_TRIM still follow the held registers.
// - Reset clears all registers, source off.
// - Edge gate bit passes or blocks edge events.
// - Polarity bits: one rising, zero falling.
// - Edge two source field selects one of four.
// - Edge one source field uses same encoding.
// - Six bit signed trim field adjusts current.
// - Range field sets current level, zero is off.
//
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
module ctu_top
  import ctu_pkg::*;
(
  // Clock and reset.
  input  wire logic        CLK_SYS,
  input  wire logic        SYS_RST,
  // AXI4-Lite write channels.
  input  wire logic [7:0]  AXI_AWADDR,
  input  wire logic        AXI_AWVALID,
  output logic             AXI_AWREADY,
  input  wire logic [31:0] AXI_WDATA,
  input  wire logic [3:0]  AXI_WSTRB,
  input  wire logic        AXI_WVALID,
  output logic             AXI_WREADY,
  output logic [1:0]       AXI_BRESP,
  output logic             AXI_BVALID,
  input  wire logic        AXI_BREADY,
  // AXI4-Lite read channels.
  input  wire logic [7:0]  AXI_ARADDR,
  input  wire logic        AXI_ARVALID,
  output logic             AXI_ARREADY,
  output logic [31:0]      AXI_RDATA,
  output logic [1:0]       AXI_RRESP,
  output logic             AXI_RVALID,
  input  wire logic        AXI_RREADY,
  // Edge sources and comparator.
  input  wire logic        EDGE_PIN_FIRST,
  input  wire logic        EDGE_PIN_SECOND,
  input  wire logic        PWM_CAPTURE_FIRST,
  input  wire logic        PWM_CAPTURE_SECOND,
  input  wire logic        COMPARATOR_TRIP,
  // Power state.
  input  wire logic        SLEEP_MODE,
  input  wire logic        IDLE_MODE,
  input  wire logic        UNIT_POWER_DISABLE,
  // Analog controls and outputs.
  output logic             CURRENT_ON,
  output logic [1:0]       CURRENT_RANGE,
  output logic [5:0]       CURRENT_TRIM,
  output logic             DISCHARGE,
  output logic             DELAY_PULSE_PIN,
  output logic             ADC_TRIGGER,
  output logic             IRQ
);

  ctu_bus_if bus ();

  logic [7:0]       main_ctrl;
  logic [7:0]       edge_ctrl;
  logic [7:0]       curr_ctrl;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  ctu_state_type    state;
  ctu_state_type    next_state;
  logic [7:0]       next_edge;
  logic [IRQ_W-1:0] next_stat;

  ctu_axil u_axil
  (
    .clk     (CLK_SYS),
    .rst     (SYS_RST),
    .awaddr  (AXI_AWADDR),
    .awvalid (AXI_AWVALID),
    .awready (AXI_AWREADY),
    .wdata   (AXI_WDATA),
    .wstrb   (AXI_WSTRB),
    .wvalid  (AXI_WVALID),
    .wready  (AXI_WREADY),
    .bresp   (AXI_BRESP),
    .bvalid  (AXI_BVALID),
    .bready  (AXI_BREADY),
    .araddr  (AXI_ARADDR),
    .arvalid (AXI_ARVALID),
    .arready (AXI_ARREADY),
    .rdata   (AXI_RDATA),
    .rresp   (AXI_RRESP),
    .rvalid  (AXI_RVALID),
    .rready  (AXI_RREADY),
    .bus     (bus)
  );

  // Write strobes; writes are dropped while the unit is power disabled, so its registers hold.
  logic wr_ok;
  logic wr_main;
  logic wr_edge;
  logic wr_curr;
  logic wr_stat;
  logic wr_mask;

  assign wr_ok   = bus.wr_en && bus.wr_strb && !UNIT_POWER_DISABLE;
  assign wr_main = wr_ok && (bus.wr_addr == OFF_MAIN);
  assign wr_edge = wr_ok && (bus.wr_addr == OFF_EDGE);
  assign wr_curr = wr_ok && (bus.wr_addr == OFF_CURR);
  assign wr_stat = wr_ok && (bus.wr_addr == OFF_STAT);
  assign wr_mask = wr_ok && (bus.wr_addr == OFF_MASK);
  assign bus.wr_err = !ctu_reg_hit(bus.wr_addr);

  // Reads; reserved bits and unmapped addresses return zero.
  assign bus.rd_err  = !ctu_reg_hit(bus.rd_addr);
  assign bus.rd_data = (bus.rd_addr == OFF_MAIN) ? main_ctrl :
                       (bus.rd_addr == OFF_EDGE) ? edge_ctrl :
                       (bus.rd_addr == OFF_CURR) ? curr_ctrl :
                       (bus.rd_addr == OFF_STAT) ? {5'h00, irq_stat} :
                       (bus.rd_addr == OFF_MASK) ? {5'h00, irq_mask} : 8'h00;

  // Edge detection.
  logic hit_one;
  logic hit_two;

  ctu_edge u_edge
  (
    .clk     (CLK_SYS),
    .rst     (SYS_RST),
    .sources ({EDGE_PIN_FIRST, EDGE_PIN_SECOND, PWM_CAPTURE_FIRST, PWM_CAPTURE_SECOND}),
    .src_one (edge_ctrl[EDGE_ONE_SRC +: 2]),
    .src_two (edge_ctrl[EDGE_TWO_SRC +: 2]),
    .pol_one (edge_ctrl[EDGE_ONE_POL]),
    .pol_two (edge_ctrl[EDGE_TWO_POL]),
    .hit_one (hit_one),
    .hit_two (hit_two)
  );

  logic unit_on;
  logic edge_pass;
  logic set_one;
  logic set_two;
  logic edge_one;
  logic edge_two;

  assign unit_on   = main_ctrl[MAIN_EN] && !UNIT_POWER_DISABLE;
  assign edge_pass = unit_on && main_ctrl[MAIN_GATE];
  assign edge_one  = edge_ctrl[EDGE_ONE_FLG];
  assign edge_two  = edge_ctrl[EDGE_TWO_FLG];
  assign set_one   = edge_pass && hit_one;
  assign set_two   = edge_pass && hit_two && (!main_ctrl[MAIN_ORDER] || edge_one);

  // Hardware set wins over a software clear in the same cycle.
  assign next_edge = wr_edge ? {bus.wr_data[7:2], bus.wr_data[1:0] | {set_two, set_one}}
                             : {edge_ctrl[7:2], edge_ctrl[1:0] | {set_two, set_one}};

  // Charge sequencer.
  logic run_ok;
  logic trip_end;

  assign run_ok = unit_on && !SLEEP_MODE && !(IDLE_MODE && main_ctrl[MAIN_IDLE_STOP]) &&
                  (curr_ctrl[CURR_RANGE +: 2] != RANGE_OFF) && !main_ctrl[MAIN_DISCH];
  assign trip_end = (state == ST_CHARGE) && main_ctrl[MAIN_DELAY] && COMPARATOR_TRIP;

  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (run_ok && edge_one && !edge_two)
          next_state = ST_CHARGE;
      ST_CHARGE:
        if (!run_ok || !edge_one)
          next_state = ST_IDLE;
        else if (edge_two || trip_end)
          next_state = ST_DONE;
      ST_DONE:
        if (!edge_one)
          next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  assign next_stat = (irq_stat & ~(wr_stat ? bus.wr_data[IRQ_W-1:0] : RST_IRQ)) |
                     {trip_end && run_ok && edge_one, set_two, set_one};

  // Register file; every register clears on reset.
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      main_ctrl <= RST_REG;
      edge_ctrl <= RST_REG;
      curr_ctrl <= RST_REG;
      irq_stat  <= RST_IRQ;
      irq_mask  <= RST_IRQ;
    end
    else if (!UNIT_POWER_DISABLE)
    begin
      if (wr_main)
        main_ctrl <= bus.wr_data & MAIN_MASK;
      if (wr_curr)
        curr_ctrl <= bus.wr_data;
      if (wr_mask)
        irq_mask <= bus.wr_data[IRQ_W-1:0];
      edge_ctrl <= next_edge;
      irq_stat  <= next_stat;
    end
  end

  // State and analog outputs, all taken from flops.
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      state           <= ST_IDLE;
      CURRENT_ON      <= 1'b0;
      DELAY_PULSE_PIN <= 1'b0;
      ADC_TRIGGER     <= 1'b0;
      IRQ             <= 1'b0;
    end
    else
    begin
      state           <= UNIT_POWER_DISABLE ? ST_IDLE : next_state;
      CURRENT_ON      <= !UNIT_POWER_DISABLE && (next_state == ST_CHARGE);
      DELAY_PULSE_PIN <= !UNIT_POWER_DISABLE && main_ctrl[MAIN_DELAY] && (next_state == ST_CHARGE);
      ADC_TRIGGER     <= main_ctrl[MAIN_TRIG] && set_two && edge_one;
      IRQ             <= !UNIT_POWER_DISABLE && |(next_stat & irq_mask);
    end
  end

  // The trim code is passed through unchanged as a signed offset to the analog trim.
  assign CURRENT_TRIM  = curr_ctrl[CURR_TRIM +: 6];
  assign CURRENT_RANGE = curr_ctrl[CURR_RANGE +: 2];
  assign DISCHARGE     = main_ctrl[MAIN_DISCH];

  a_sleep_forces_off: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    SLEEP_MODE |=> !CURRENT_ON)
    else $error("Current source on after sleep entry.");

  a_idle_stop_off: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    IDLE_MODE && main_ctrl[MAIN_IDLE_STOP] |=> !CURRENT_ON && !DELAY_PULSE_PIN)
    else $error("Current source on in idle with stop set.");

  a_power_disable_off: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    UNIT_POWER_DISABLE ##0 $stable(main_ctrl) |=> !CURRENT_ON && !IRQ && $stable(main_ctrl))
    else $error("Unit active while power disabled.");

  a_reset_clears: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    $past(SYS_RST) |-> main_ctrl == RST_REG && edge_ctrl == RST_REG && curr_ctrl == RST_REG && !CURRENT_ON)
    else $error("Registers not cleared by reset.");

  a_enable_gates_source: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    !main_ctrl[MAIN_EN] |=> !CURRENT_ON)
    else $error("Current source on while unit disabled.");

  a_gate_blocks_edges: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    !main_ctrl[MAIN_GATE] && !wr_edge |=> $stable(edge_ctrl[1:0]))
    else $error("Edge flag changed while edges blocked.");

  a_order_enforced: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    main_ctrl[MAIN_ORDER] && !edge_one && !edge_two && !wr_edge |=> !edge_ctrl[EDGE_TWO_FLG])
    else $error("Edge two accepted before edge one.");

  a_delay_pulse_mode: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    DELAY_PULSE_PIN |-> CURRENT_ON && $past(main_ctrl[MAIN_DELAY]))
    else $error("Delay pulse outside delay mode.");

  a_trip_ends_pulse: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    DELAY_PULSE_PIN && COMPARATOR_TRIP && main_ctrl[MAIN_DELAY] |=> !DELAY_PULSE_PIN)
    else $error("Pulse not ended by comparator trip.");

  a_range_off: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    curr_ctrl[CURR_RANGE +: 2] == RANGE_OFF |=> !CURRENT_ON)
    else $error("Current source on with range off.");

  a_discharge_stops: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    main_ctrl[MAIN_DISCH] |=> DISCHARGE || $past(wr_main) ##0 !CURRENT_ON)
    else $error("Charging while output grounded.");

  a_trigger_cause: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    ADC_TRIGGER |-> $past(main_ctrl[MAIN_TRIG]) && edge_ctrl[EDGE_TWO_FLG] && edge_ctrl[EDGE_ONE_FLG])
    else $error("Conversion trigger without edge two.");

  a_charge_window: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    CURRENT_ON |-> $past(edge_one) && !$past(edge_two) || $past(state) == ST_CHARGE)
    else $error("Charging outside the edge window.");

endmodule

// ---- verif/ctu_far_model.sv ----
// Far-side model: edge source levels and a comparator watching the charged capacitor.
`timescale 1ns/100ps
module ctu_far_model
#(
  parameter int TRIP_CYCLES = 12
)
(
  // Clock.
  input  wire logic       clk,
  // Requested levels and analog state.
  input  wire logic [3:0] levels,
  input  wire logic       charging,
  input  wire logic       grounded,
  // Toward the unit.
  output logic            pin_first,
  output logic            pin_second,
  output logic            pwm_first,
  output logic            pwm_second,
  output logic            trip
);
  int unsigned charge = 0;

  assign pin_first  = levels[3];
  assign pin_second = levels[2];
  assign pwm_first  = levels[1];
  assign pwm_second = levels[0];

  // The capacitor keeps its charge once the source stops; only grounding empties it.
  always @(posedge clk)
  begin
    if (grounded)
      charge <= 0;
    else if (charging)
      charge <= charge + 1;
  end

  assign trip = (charge >= TRIP_CYCLES);
endmodule

// ---- verif/testbench.sv ----
// Self-checking bench for the charge time unit.
`timescale 1ns/100ps
module testbench
  import ctu_pkg::*;
;
  localparam int TRIP = 12;
  logic        clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, pf, ps, cf, cs, trip;
  logic        sleep, idle, pd, cur_on, disch, dly, adc, irq, p;
  logic [7:0]  awaddr, araddr, d;
  logic [31:0] wdata, rdata, q;
  logic [3:0]  wstrb, lvl;
  logic [1:0]  bresp, rresp, rng, r;
  logic [5:0]  trim;
  int          miscompares, total_checks, seed, trig_cnt, n, w;

  ctu_top u_dut (.CLK_SYS(clk), .SYS_RST(rst), .AXI_AWADDR(awaddr), .AXI_AWVALID(awvalid),
    .AXI_AWREADY(awready), .AXI_WDATA(wdata), .AXI_WSTRB(wstrb), .AXI_WVALID(wvalid), .AXI_WREADY(wready),
    .AXI_BRESP(bresp), .AXI_BVALID(bvalid), .AXI_BREADY(bready), .AXI_ARADDR(araddr), .AXI_ARVALID(arvalid),
    .AXI_ARREADY(arready), .AXI_RDATA(rdata), .AXI_RRESP(rresp), .AXI_RVALID(rvalid), .AXI_RREADY(rready),
    .EDGE_PIN_FIRST(pf), .EDGE_PIN_SECOND(ps), .PWM_CAPTURE_FIRST(cf), .PWM_CAPTURE_SECOND(cs),
    .COMPARATOR_TRIP(trip), .SLEEP_MODE(sleep), .IDLE_MODE(idle), .UNIT_POWER_DISABLE(pd),
    .CURRENT_ON(cur_on), .CURRENT_RANGE(rng), .CURRENT_TRIM(trim), .DISCHARGE(disch),
    .DELAY_PULSE_PIN(dly), .ADC_TRIGGER(adc), .IRQ(irq));

  ctu_far_model #(.TRIP_CYCLES(TRIP)) u_far (.clk(clk), .levels(lvl), .charging(cur_on), .grounded(disch),
    .pin_first(pf), .pin_second(ps), .pwm_first(cf), .pwm_second(cs), .trip(trip));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (adc === 1'b1)
      trig_cnt <= trig_cnt + 1;
  end

  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task stuck;
    miscompares++;
    $display("mismatch bus answer expected 1 seen 0");
    end_of_test();
  endtask

  task wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] resp);
    int k;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h000000, v};
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 50; k++)
    begin
      @(posedge clk);
      if (awvalid && awready === 1'b1)
        awvalid <= 1'b0;
      if (wvalid && wready === 1'b1)
        wvalid <= 1'b0;
      if (bvalid === 1'b1)
      begin
        resp = bresp;
        bready <= 1'b0;
        return;
      end
    end
    stuck();
  endtask

  task rd(input logic [7:0] a, output logic [31:0] data, output logic [1:0] resp);
    int k;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 50; k++)
    begin
      @(posedge clk);
      if (arvalid && arready === 1'b1)
        arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        data = rdata;
        resp = rresp;
        rready <= 1'b0;
        return;
      end
    end
    stuck();
  endtask

  // Idle level first, so the selected source then makes exactly one edge of polarity pol.
  task pulse(input int c, input logic pol);
    @(posedge clk);
    lvl <= {4{~pol}};
    repeat (3) @(posedge clk);
    lvl[c] <= pol;
    repeat (3) @(posedge clk);
  endtask

  task tick;
    repeat (3) @(posedge clk);
  endtask

  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, sleep, idle, pd} = 8'h00;
    {awaddr, araddr, wdata, lvl, miscompares, total_checks, trig_cnt} = 0;
    wstrb = 4'h1;
    seed = 32'hd299;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    tick();
    chk("current on", cur_on, 0);
    for (n = 0; n < 5; n++)
    begin
      rd(8'(n * 4), q, r);
      chk("reset value", q, 0);
    end
    wstrb <= 4'h0;
    wr(OFF_CURR, 8'hff, r);
    wstrb <= 4'h1;
    rd(OFF_CURR, q, r);
    chk("strobe off write", q, 0);
    for (n = 0; n < 6; n++)
    begin
      d = (n == 0) ? 8'h7d : (n == 1) ? 8'h86 : 8'($random(seed));
      wr(OFF_CURR, d, r);
      rd(OFF_CURR, q, r);
      chk("current reg", q, {24'h0, d});
      chk("trim out", trim, d[7:2]);
      chk("range out", rng, d[1:0]);
    end
    d = 8'($random(seed)) | 8'h40;
    wr(OFF_MAIN, d, r);
    rd(OFF_MAIN, q, r);
    chk("main reg", q, d & MAIN_MASK);
    wr(8'h14, 8'hff, r);
    chk("unmapped write", r, RESP_SLVERR);
    rd(8'h14, q, r);
    chk("unmapped read resp", r, RESP_SLVERR);
    chk("unmapped read", q, 0);
    wr(OFF_MAIN, 8'h82, r);
    tick();
    chk("discharge", disch, 1);
    wr(OFF_MAIN, 8'h8c, r);
    tick();
    chk("discharge", disch, 0);
    wr(OFF_CURR, 8'h01, r);
    for (n = 0; n < 4; n++)
    begin
      p = (n < 2) ? 1'(n) : 1'($random(seed));
      wr(OFF_EDGE, {3'b000, p, 2'(n), 2'b00}, r);
      pulse(n, p);
      rd(OFF_EDGE, q, r);
      chk("edge one flag", q[1:0], 2'b01);
      chk("charging", cur_on, 1);
      wr(OFF_EDGE, {p, 2'(n), 5'b00001}, r);
      pulse(n, p);
      rd(OFF_EDGE, q, r);
      chk("edge two flag", q[1:0], 2'b11);
      chk("stopped", cur_on, 0);
      wr(OFF_EDGE, 8'h00, r);
    end
    wr(OFF_MAIN, 8'h80, r);
    wr(OFF_EDGE, 8'h1c, r);
    pulse(3, 1'b1);
    rd(OFF_EDGE, q, r);
    chk("gated flag", q[0], 0);
    wr(OFF_MAIN, 8'h8d, r);
    wr(OFF_EDGE, 8'hf8, r);
    w = trig_cnt;
    pulse(3, 1'b1);
    rd(OFF_EDGE, q, r);
    chk("early edge two", q[1:0], 2'b00);
    pulse(2, 1'b1);
    pulse(3, 1'b1);
    rd(OFF_EDGE, q, r);
    chk("ordered flags", q[1:0], 2'b11);
    chk("adc trigger", trig_cnt - w, 1);
    chk("masked irq", irq, 0);
    wr(OFF_MASK, 8'h03, r);
    tick();
    chk("irq", irq, 1);
    wr(OFF_STAT, 8'h03, r);
    rd(OFF_STAT, q, r);
    chk("status cleared", q, 0);
    tick();
    chk("irq clear", irq, 0);
    wr(OFF_MAIN, 8'h80, r);
    wr(OFF_EDGE, 8'h00, r);
    wr(OFF_EDGE, 8'h01, r);
    tick();
    chk("sw charge", cur_on, 1);
    sleep <= 1'b1;
    tick();
    chk("sleep off", cur_on, 0);
    sleep <= 1'b0;
    wr(OFF_EDGE, 8'h00, r);
    wr(OFF_EDGE, 8'h01, r);
    idle <= 1'b1;
    tick();
    chk("idle runs", cur_on, 1);
    idle <= 1'b0;
    wr(OFF_EDGE, 8'h00, r);
    wr(OFF_MAIN, 8'ha0, r);
    idle <= 1'b1;
    wr(OFF_EDGE, 8'h01, r);
    tick();
    chk("idle stop", cur_on, 0);
    idle <= 1'b0;
    wr(OFF_EDGE, 8'h00, r);
    wr(OFF_MAIN, 8'h80, r);
    wr(OFF_EDGE, 8'h01, r);
    pd <= 1'b1;
    tick();
    chk("power off", cur_on, 0);
    wr(OFF_MAIN, 8'h00, r);
    pd <= 1'b0;
    rd(OFF_MAIN, q, r);
    chk("frozen reg", q, 8'h80);
    wr(OFF_MAIN, 8'h00, r);
    tick();
    chk("disabled", cur_on, 0);
    wr(OFF_EDGE, 8'h00, r);
    wr(OFF_MAIN, 8'h82, r);
    wr(OFF_MAIN, 8'h90, r);
    wr(OFF_MASK, 8'h04, r);
    wr(OFF_EDGE, 8'h01, r);
    for (n = 0; n < 40 && dly !== 1'b1; n++)
      @(posedge clk);
    w = 0;
    for (n = 0; n < 60 && dly === 1'b1; n++)
    begin
      @(posedge clk);
      w++;
    end
    chk("pulse width", 32'(w >= TRIP - 2 && w <= TRIP + 4), 1);
    rd(OFF_STAT, q, r);
    chk("trip status", q[2], 1);
    tick();
    chk("trip irq", irq, 1);
    wr(OFF_EDGE, 8'h00, r);
    wr(OFF_MAIN, 8'h80, r);
    wr(OFF_EDGE, 8'h01, r);
    tick();
    chk("charge before reset", cur_on, 1);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    tick();
    chk("reset stops charge", cur_on, 0);
    chk("reset irq", irq, 0);
    rd(OFF_EDGE, q, r);
    chk("reset edge reg", q, 0);
    rd(OFF_MAIN, q, r);
    chk("reset main reg", q, 0);
    end_of_test();
  end
endmodule
